// [hdl/sdof_filter.sv]
`include "sdof_regs.svh"

module sdof_cic #(
  parameter int ACC_W = 32,
  parameter int DEC_W = 8
) (
  input  wire logic                    ref_clk,
  input  wire logic                    nrst,
  input  wire logic                    enable,
  input  wire logic                    tick,
  input  wire logic                    bit_in,
  input  wire logic [1:0]              order,
  input  wire logic [DEC_W-1:0]        decim,
  output logic                         out_valid,
  output logic signed [ACC_W-1:0]      out_data
);
  logic signed [ACC_W-1:0] integ_r [3];
  logic signed [ACC_W-1:0] integ_nxt [3];
  logic signed [ACC_W-1:0] dly_r [3];
  logic signed [ACC_W-1:0] dly_nxt [3];
  logic signed [ACC_W-1:0] out_r;
  logic signed [ACC_W-1:0] out_nxt;
  logic signed [ACC_W-1:0] comb_val;
  logic signed [ACC_W-1:0] stage;
  logic [DEC_W-1:0]        cnt_r;
  logic [DEC_W-1:0]        cnt_nxt;
  logic                    vld_r;
  logic                    vld_nxt;
  logic [1:0]              ord_idx;

  // order 0 is treated as order 1; accumulators wrap, which the
  // differentiators undo as long as ACC_W covers order*log2(decim)+1
  assign ord_idx = (order == 2'h0) ? 2'h0 : order - 2'h1;

  always_comb begin
    integ_nxt = integ_r;
    dly_nxt   = dly_r;
    out_nxt   = out_r;
    cnt_nxt   = cnt_r;
    vld_nxt   = 1'b0;
    comb_val  = '0;
    stage     = '0;
    if (!enable) begin
      for (int k = 0; k < 3; k++) begin
        integ_nxt[k] = '0;
        dly_nxt[k]   = '0;
      end
      cnt_nxt = '0;
    end else if (tick) begin
      integ_nxt[0] = integ_r[0] + (bit_in ? ACC_W'(1) : {ACC_W{1'b1}});
      integ_nxt[1] = integ_r[1] + integ_nxt[0];
      integ_nxt[2] = integ_r[2] + integ_nxt[1];
      if (cnt_r >= decim - DEC_W'(1)) begin
        cnt_nxt  = '0;
        comb_val = integ_nxt[ord_idx];
        for (int k = 0; k < 3; k++) begin
          if (k <= int'(ord_idx)) begin
            stage      = comb_val - dly_r[k];
            dly_nxt[k] = comb_val;
            comb_val   = stage;
          end
        end
        out_nxt = comb_val;
        vld_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + DEC_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < 3; k++) begin
        integ_r[k] <= '0;
        dly_r[k]   <= '0;
      end
      out_r <= '0;
      cnt_r <= '0;
      vld_r <= 1'b0;
    end else begin
      integ_r <= integ_nxt;
      dly_r   <= dly_nxt;
      out_r   <= out_nxt;
      cnt_r   <= cnt_nxt;
      vld_r   <= vld_nxt;
    end
  end

  assign out_valid = vld_r;
  assign out_data  = out_r;
endmodule

module sdof_filter #(
  parameter int ACC_W = 32,
  parameter int DEC_W = 8,
  parameter int WIN_W = 8,
  parameter int IRQ_W = 8
) (
  input  wire logic                            ref_clk,
  input  wire logic                            nrst,
  input  wire logic [`SDOF_PAIRS-1:0]          modulator_bit_stream,
  output logic                                 mod_clk,
  input  wire logic [7:0]                      mod_clk_div,
  input  wire logic                            mod_clk_enable,
  input  wire logic                            start_on_sync,
  input  wire logic                            sync_trigger,
  input  wire logic [`SDOF_PAIRS-1:0]          pair_enable,
  input  wire logic [`SDOF_PAIRS-1:0]          pair_group,
  input  wire logic [`SDOF_GROUPS-1:0][1:0]        prim_order,
  input  wire logic [`SDOF_GROUPS-1:0][DEC_W-1:0]  prim_decim,
  input  wire logic [`SDOF_GROUPS-1:0][ACC_W-1:0]  prim_bias,
  input  wire logic [`SDOF_GROUPS-1:0][15:0]       prim_gain,
  input  wire logic [`SDOF_GROUPS-1:0][1:0]        sec_order,
  input  wire logic [`SDOF_GROUPS-1:0][DEC_W-1:0]  sec_decim,
  input  wire logic [`SDOF_GROUPS-1:0][ACC_W-1:0]  upper_limit,
  input  wire logic [`SDOF_GROUPS-1:0][ACC_W-1:0]  lower_limit,
  input  wire logic [`SDOF_GROUPS-1:0][WIN_W-1:0]  overload_min_count,
  input  wire logic [`SDOF_GROUPS-1:0][WIN_W-1:0]  overload_window_length,
  input  wire logic [`SDOF_PAIRS-1:0]          overload_clear,
  output logic [`SDOF_PAIRS-1:0]               overload_trip,
  input  wire logic                            dma_enable,
  input  wire logic                            data_irq_mask,
  input  wire logic [IRQ_W-1:0]                dma_irq_count,
  output logic                                 dma_valid,
  input  wire logic                            dma_ready,
  output logic [15:0]                          dma_data,
  output logic [1:0]                           dma_pair,
  output logic                                 data_irq
);
  // ---------------- modulator clock ----------------
  sdof_pkg::sdof_run_type run_r;
  sdof_pkg::sdof_run_type run_nxt;
  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic       mclk_r;
  logic       mclk_nxt;
  logic       bit_tick;
  logic       running;

  assign running  = (run_r == sdof_pkg::SDOF_RUN);
  // sample in the cycle the clock rises: data launched on the previous
  // edge has had half a period to settle
  // gated by the enable too, so a stop never samples a bit without a rising edge
  assign bit_tick = running && mod_clk_enable && (div_r >= mod_clk_div) && !mclk_r;

  always_comb begin
    run_nxt  = run_r;
    div_nxt  = div_r;
    mclk_nxt = mclk_r;
    case (run_r)
      sdof_pkg::SDOF_IDLE: begin
        if (mod_clk_enable) begin
          run_nxt = start_on_sync ? sdof_pkg::SDOF_ARMED : sdof_pkg::SDOF_RUN;
        end
      end
      sdof_pkg::SDOF_ARMED: begin
        if (!mod_clk_enable) begin
          run_nxt = sdof_pkg::SDOF_IDLE;
        end else if (sync_trigger) begin
          run_nxt = sdof_pkg::SDOF_RUN;
        end
      end
      sdof_pkg::SDOF_RUN: begin
        if (!mod_clk_enable) begin
          run_nxt = sdof_pkg::SDOF_IDLE;
        end
      end
      default: run_nxt = sdof_pkg::SDOF_IDLE;
    endcase
    if (running && mod_clk_enable) begin
      if (div_r >= mod_clk_div) begin
        div_nxt  = 8'h00;
        mclk_nxt = !mclk_r;
      end else begin
        div_nxt = div_r + 8'h01;
      end
    end else begin
      div_nxt  = 8'h00;
      mclk_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      run_r  <= sdof_pkg::SDOF_IDLE;
      div_r  <= `SDOF_DIV_RESET;
      mclk_r <= 1'b0;
    end else begin
      run_r  <= run_nxt;
      div_r  <= div_nxt;
      mclk_r <= mclk_nxt;
    end
  end

  assign mod_clk = mclk_r;

  // ---------------- filter pairs ----------------
  logic [`SDOF_PAIRS-1:0] pend_r;
  logic [`SDOF_PAIRS-1:0] grant;
  logic [15:0]            samp_r [`SDOF_PAIRS];

  for (genvar i = 0; i < `SDOF_PAIRS; i++) begin : g_pair
    logic                    en;
    logic                    grp;
    logic                    p_vld;
    logic                    s_vld;
    logic signed [ACC_W-1:0] p_dat;
    logic signed [ACC_W-1:0] s_dat;
    logic signed [ACC_W:0]   biased;
    logic signed [ACC_W+16:0] scaled;
    logic [15:0]             sat;
    logic                    ovl;
    logic [WIN_W-1:0]        win_r;
    logic [WIN_W-1:0]        win_nxt;
    logic [WIN_W-1:0]        hit_r;
    logic [WIN_W-1:0]        hit_nxt;
    logic                    trip_r;
    logic                    trip_nxt;
    logic                    pend_nxt;
    logic [15:0]             samp_nxt;

    assign en  = pair_enable[i] && running;
    assign grp = pair_group[i];

    sdof_cic #(.ACC_W(ACC_W), .DEC_W(DEC_W)) u_prim (
      .ref_clk   (ref_clk),
      .nrst      (nrst),
      .enable    (en),
      .tick      (bit_tick),
      .bit_in    (modulator_bit_stream[i]),
      .order     (prim_order[grp]),
      .decim     (prim_decim[grp]),
      .out_valid (p_vld),
      .out_data  (p_dat)
    );

    sdof_cic #(.ACC_W(ACC_W), .DEC_W(DEC_W)) u_sec (
      .ref_clk   (ref_clk),
      .nrst      (nrst),
      .enable    (en),
      .tick      (bit_tick),
      .bit_in    (modulator_bit_stream[i]),
      .order     (sec_order[grp]),
      .decim     (sec_decim[grp]),
      .out_valid (s_vld),
      .out_data  (s_dat)
    );

    always_comb begin
      biased = p_dat + $signed(prim_bias[grp]);
      scaled = (ACC_W+17)'(biased * $signed({1'b0, prim_gain[grp]})) >>> `SDOF_GAIN_SHIFT;
      if (scaled > $signed(`SDOF_SAT_MAX)) begin
        sat = `SDOF_SAT_MAX;
      end else if (scaled < $signed({{(ACC_W+1){1'b1}}, `SDOF_SAT_MIN})) begin
        sat = `SDOF_SAT_MIN;
      end else begin
        sat = scaled[15:0];
      end
      ovl = (s_dat > $signed(upper_limit[grp])) || (s_dat < $signed(lower_limit[grp]));
      win_nxt  = win_r;
      hit_nxt  = hit_r;
      trip_nxt = trip_r && !overload_clear[i];
      if (!pair_enable[i]) begin
        win_nxt  = '0;
        hit_nxt  = '0;
        trip_nxt = 1'b0;
      end else if (s_vld) begin
        hit_nxt = hit_r + WIN_W'(ovl);
        if (hit_nxt >= overload_min_count[grp] && ovl) begin
          trip_nxt = 1'b1;
        end
        if (win_r + WIN_W'(1) >= overload_window_length[grp]) begin
          win_nxt = '0;
          hit_nxt = '0;
        end else begin
          win_nxt = win_r + WIN_W'(1);
        end
      end
      // a new sample outranks the grant that empties the slot
      pend_nxt = (pend_r[i] && !grant[i]) || (p_vld && dma_enable);
      samp_nxt = (p_vld && dma_enable) ? sat : samp_r[i];
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        win_r     <= '0;
        hit_r     <= '0;
        trip_r    <= 1'b0;
        pend_r[i] <= 1'b0;
        samp_r[i] <= 16'h0000;
      end else begin
        win_r     <= win_nxt;
        hit_r     <= hit_nxt;
        trip_r    <= trip_nxt;
        pend_r[i] <= pend_nxt;
        samp_r[i] <= samp_nxt;
      end
    end

    assign overload_trip[i] = trip_r;
  end

  // ---------------- dma hand-off and data interrupt ----------------
  logic             dv_r;
  logic             dv_nxt;
  logic [15:0]      dd_r;
  logic [15:0]      dd_nxt;
  logic [1:0]       dp_r;
  logic [1:0]       dp_nxt;
  logic [IRQ_W-1:0] xfer_r;
  logic [IRQ_W-1:0] xfer_nxt;
  logic             irq_r;
  logic             irq_nxt;
  logic             found;

  // fixed priority: pair 0 first; each pair holds only its latest sample
  always_comb begin
    grant  = '0;
    found  = 1'b0;
    dv_nxt = dv_r && !dma_ready;
    dd_nxt = dd_r;
    dp_nxt = dp_r;
    if (!dv_r || dma_ready) begin
      for (int k = 0; k < `SDOF_PAIRS; k++) begin
        if (pend_r[k] && !found) begin
          found    = 1'b1;
          grant[k] = 1'b1;
          dv_nxt   = 1'b1;
          dd_nxt   = samp_r[k];
          dp_nxt   = 2'(k);
        end
      end
    end
    xfer_nxt = xfer_r;
    irq_nxt  = 1'b0;
    if (dv_r && dma_ready) begin
      if (xfer_r + IRQ_W'(1) >= dma_irq_count) begin
        xfer_nxt = '0;
        irq_nxt  = !data_irq_mask;
      end else begin
        xfer_nxt = xfer_r + IRQ_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dv_r   <= 1'b0;
      dd_r   <= 16'h0000;
      dp_r   <= 2'h0;
      xfer_r <= '0;
      irq_r  <= 1'b0;
    end else begin
      dv_r   <= dv_nxt;
      dd_r   <= dd_nxt;
      dp_r   <= dp_nxt;
      xfer_r <= xfer_nxt;
      irq_r  <= irq_nxt;
    end
  end

  assign dma_valid = dv_r;
  assign dma_data  = dd_r;
  assign dma_pair  = dp_r;
  assign data_irq  = irq_r;
endmodule

// [hdl/sdof_regs.svh]
`ifndef SDOF_REGS_SVH
`define SDOF_REGS_SVH

// number of filter pairs and configuration groups
`define SDOF_PAIRS        4
`define SDOF_GROUPS       2
// right shift applied after the gain multiply (gain is fixed point, 8 fraction bits)
`define SDOF_GAIN_SHIFT   8
// saturation limits of the signed 16-bit primary result
`define SDOF_SAT_MAX      16'h7fff
`define SDOF_SAT_MIN      16'h8000
// reset value of the modulator clock half-period divider (5 ref_clk cycles -> 10 MHz)
`define SDOF_DIV_RESET    8'h04

`endif

// [hdl/sdof_pkg.sv]
package sdof_pkg;

  // modulator clock run control
  typedef enum logic [1:0] {
    SDOF_IDLE,
    SDOF_ARMED,
    SDOF_RUN
  } sdof_run_type;

endpackage

// [tb/sdof_props.sv]
module sdof_props (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        mod_clk,
  input wire logic [7:0]  mod_clk_div,
  input wire logic        mod_clk_enable,
  input wire logic        start_on_sync,
  input wire logic        sync_trigger,
  input wire logic [3:0]  pair_enable,
  input wire logic [3:0]  overload_clear,
  input wire logic [3:0]  overload_trip,
  input wire logic        dma_enable,
  input wire logic        data_irq_mask,
  input wire logic        dma_valid,
  input wire logic        dma_ready,
  input wire logic [15:0] dma_data,
  input wire logic [1:0]  dma_pair,
  input wire logic        data_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] hi_cnt_r;
  logic [8:0] hi_cnt_nxt;
  // length of the current high phase of the modulator clock
  always_comb begin
    hi_cnt_nxt = mod_clk ? hi_cnt_r + 9'h001 : 9'h000;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hi_cnt_r <= 9'h000;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_clk_high_time:
    assert property ($fell(mod_clk) && mod_clk_enable && $past(mod_clk_enable)
      && $stable(mod_clk_div) |-> hi_cnt_r == {1'b0, mod_clk_div} + 9'h001)
      else $error("modulator clock high phase has wrong length");
  a_clk_stays_low:
    assert property (!mod_clk_enable && !$past(mod_clk_enable) |-> !mod_clk)
      else $error("modulator clock runs while disabled");
  a_clk_first_rise:
    assert property ($rose(mod_clk_enable) && !start_on_sync && mod_clk_div == 8'h04
      |-> !mod_clk[*5] ##[1:4] mod_clk) else $error("modulator clock start delay wrong");
  a_sync_waits:
    assert property ($rose(mod_clk_enable) && start_on_sync
      ##1 (mod_clk_enable && !sync_trigger)[*8] |-> !mod_clk)
      else $error("armed clock started without sync");
  a_dma_word_stands:
    assert property (dma_valid && !dma_ready |=> dma_valid && $stable(dma_data)
      && $stable(dma_pair)) else $error("dma word changed before acceptance");
  a_irq_after_accept:
    assert property (data_irq |-> $past(dma_valid) && $past(dma_ready))
      else $error("data interrupt without a transfer");
  a_irq_masked:
    assert property (data_irq_mask && $past(data_irq_mask) && $past(data_irq_mask, 2)
      |-> !data_irq) else $error("masked data interrupt raised");
  a_dma_gated:
    assert property ($rose(dma_valid) |-> $past(dma_enable) || $past(dma_enable, 2)
      || $past(dma_enable, 3)) else $error("dma word offered while disabled");
  a_trip_sticky:
    assert property (!(|($past(overload_trip) & ~overload_trip & ~$past(overload_clear)
      & ~$past(overload_clear, 2) & $past(pair_enable) & $past(pair_enable, 2))))
      else $error("overload trip dropped without clear");
  c_trip: cover property ($rose(|overload_trip));
  c_irq: cover property (data_irq);
  c_stall: cover property (dma_valid && !dma_ready);
endmodule

// [tb/sdof_mod_model.sv]
module sdof_mod_model (
  input  wire logic       mod_clk,
  input  wire logic [3:0] ones,
  output logic      [3:0] bits
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bits = 4'h0;
  // launched on the falling edge so each bit is settled half a period before sampling
  always @(negedge mod_clk) begin
    bits <= ones;
  end
endmodule

// [tb/sdof_filter_tb_top.sv]
module sdof_filter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, nrst = 1'b0, men = 1'b0, sos = 1'b0, sync = 1'b0;
  logic den = 1'b1, msk = 1'b0, rdy = 1'b0, mclk, dv, irq;
  logic [3:0] bits, trip, pen = 4'h0, grp = 4'b1100, clr = 4'h0, ones = 4'b1001;
  logic [7:0] div = 8'h04, icnt = 8'h04;
  logic [15:0] dd;
  logic [1:0] dp;
  // group 0 order one above the second-order modulator, group 1 order two; short decimation keeps the run brief
  logic [1:0][1:0] po = {2'h2, 2'h3}, so = {2'h1, 2'h1};
  logic [1:0][7:0] pd = {8'h08, 8'h08}, sd = {8'h04, 8'h04};
  logic [1:0][7:0] mc = {8'h03, 8'h02}, wl = {8'h08, 8'h04};
  logic [1:0][31:0] pb = {32'hffff_8000, 32'hffff_fff4};
  logic [1:0][31:0] ul = {32'h0000_0064, 32'h0000_0000}, ll = {32'h0000_0001, 32'hffff_ff9c};
  logic [1:0][15:0] pg = {16'h0100, 16'h8000};
  int error_cnt = 0, n_tests = 0, cyc = 0;
  sdof_filter dut (.ref_clk(ref_clk), .nrst(nrst), .modulator_bit_stream(bits),
    .mod_clk(mclk), .mod_clk_div(div), .mod_clk_enable(men), .start_on_sync(sos),
    .sync_trigger(sync), .pair_enable(pen), .pair_group(grp), .prim_order(po),
    .prim_decim(pd), .prim_bias(pb), .prim_gain(pg), .sec_order(so), .sec_decim(sd),
    .upper_limit(ul), .lower_limit(ll), .overload_min_count(mc),
    .overload_window_length(wl), .overload_clear(clr), .overload_trip(trip),
    .dma_enable(den), .data_irq_mask(msk), .dma_irq_count(icnt), .dma_valid(dv),
    .dma_ready(rdy), .dma_data(dd), .dma_pair(dp), .data_irq(irq));
  sdof_mod_model u_mod (.mod_clk(mclk), .ones(ones), .bits(bits));
  always #5 ref_clk = ~ref_clk;
  task automatic test_done();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic step(int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // settled sample of a constant stream: +D^O for ones, -D^O for zeros, then bias, gain, saturation
  function automatic logic [15:0] exp16(int i);
    int g;
    longint r, b, k;
    g = grp[i];
    r = (ones[i] ? 1 : -1) * longint'(pd[g]) ** po[g];
    b = $signed(pb[g]);
    k = pg[g];
    r = ((r + b) * k) >>> 8;
    return r > 32767 ? 16'h7fff : r < -32768 ? 16'h8000 : r[15:0];
  endfunction
  task automatic t_primary();
    int k, nirq;
    logic [15:0] last [4];
    k = 0;
    nirq = 0;
    pen = 4'hf;
    men = 1'b1;
    // stall ends before the second output, so no pair is pending twice
    step(100);
    chk(dv, 1);
    rdy = 1'b1;
    while (k < 24) begin
      if (dv) begin
        chk(dp, k % 4);
        last[dp] = dd;
        k++;
      end
      nirq += irq;
      step();
    end
    repeat (2) begin
      nirq += irq;
      step();
    end
    chk(nirq, 6);
    for (int i = 0; i < 4; i++) chk(last[i], exp16(i));
  endtask
  task automatic t_overload();
    int n;
    pen = 4'h0;
    step(3);
    chk(trip, 0);
    pen = 4'hf;
    n = 0;
    while (!trip[0] && n < 200) begin
      step();
      n++;
    end
    chk(trip, 4'b0001);
    n = 0;
    while (!trip[2] && n < 60) begin
      step();
      n++;
    end
    chk(trip, 4'b0101);
    clr = 4'b0100;
    step(2);
    clr = 4'h0;
    step();
    chk(trip, 4'b0001);
  endtask
  task automatic t_dma_gate();
    int acc, nirq;
    acc = 0;
    nirq = 0;
    den = 1'b0;
    step(20);
    repeat (200) begin
      acc += dv;
      step();
    end
    chk(acc, 0);
    den = 1'b1;
    msk = 1'b1;
    repeat (400) begin
      nirq += irq;
      acc += dv;
      step();
    end
    chk(nirq, 0);
    chk(acc >= 16, 1);
    msk = 1'b0;
  endtask
  task automatic t_sync();
    int n;
    pen = 4'h0;
    men = 1'b0;
    step(20);
    chk(mclk, 0);
    sos = 1'b1;
    men = 1'b1;
    n = 0;
    repeat (40) begin
      n += mclk;
      step();
    end
    chk(n, 0);
    sync = 1'b1;
    step();
    sync = 1'b0;
    n = 0;
    while (!mclk && n < 20) begin
      step();
      n++;
    end
    chk(mclk, 1);
  endtask
  task automatic t_current();
    logic [15:0] last [2];
    pd[0] = 8'h55;
    pg[0] = 16'h0001;
    pen = 4'hf;
    // four outputs at the low end of the current feedback range
    repeat (3600) begin
      if (dv && dp < 2'h2) last[dp[0]] = dd;
      step();
    end
    for (int i = 0; i < 2; i++) chk(last[i], exp16(i));
  endtask
  initial begin
    step(3);
    chk({mclk, dv, irq, trip, dp, dd}, 32'h0000_0000);
    step(3);
    nrst = 1'b1;
    step(2);
    t_primary();
    t_overload();
    t_dma_gate();
    t_sync();
    t_current();
    test_done();
  end
endmodule
bind sdof_filter sdof_props u_props (.ref_clk, .nrst, .mod_clk, .mod_clk_div, .mod_clk_enable,
  .start_on_sync, .sync_trigger, .pair_enable, .overload_clear, .overload_trip, .dma_enable,
  .data_irq_mask, .dma_valid, .dma_ready, .dma_data, .dma_pair, .data_irq);
